// ---- sis_pkg.sv ----
// Shared constants for the sensor two-wire register slave and its master
package sis_pkg;

    // -------------------------------------------------------------
    // Addressing
    // -------------------------------------------------------------
    localparam logic [6:0] SIS_SLAVE_ADDR  = 7'h33;
    localparam logic [7:0] SIS_CALL_WRITE  = 8'h66;
    localparam logic [7:0] SIS_CALL_READ   = 8'h67;
    localparam int         SIS_REG_COUNT   = 256;

    // -------------------------------------------------------------
    // Byte framing
    // -------------------------------------------------------------
    localparam logic [3:0] SIS_LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] SIS_ACK_BIT       = 4'h8;

    // Byte position inside one transaction
    localparam logic [1:0] SIS_PH_CALL = 2'h0;
    localparam logic [1:0] SIS_PH_REG  = 2'h1;
    localparam logic [1:0] SIS_PH_DATA = 2'h2;
    localparam logic [1:0] SIS_PH_DONE = 2'h3;

    // -------------------------------------------------------------
    // Serial clock timing, in periods of sys_clk
    // -------------------------------------------------------------
    localparam int SIS_SCL_DIV_MIN  = 24;
    localparam int SIS_SCL_LOW_MIN  = 8;
    localparam int SIS_QUARTER_RAW  = (SIS_SCL_DIV_MIN + 3) / 4;
    localparam int SIS_QUARTER_INT  = (SIS_QUARTER_RAW > SIS_SCL_LOW_MIN / 2)
                                    ? SIS_QUARTER_RAW : SIS_SCL_LOW_MIN / 2;
    localparam logic [3:0] SIS_QUARTER_LAST = 4'(SIS_QUARTER_INT - 1);

    // Master sequence: index of the byte on the wire
    localparam logic [2:0] SIS_STEP_REG     = 3'h1;
    localparam logic [2:0] SIS_STEP_LAST_WR = 3'h2;
    localparam logic [2:0] SIS_STEP_LAST_RD = 3'h3;

endpackage : sis_pkg

// ---- sis_bus_if.sv ----
// Open-drain two-wire link joining the sensor slave and the bus master
`timescale 1ns/100ps
`default_nettype none

interface sis_bus_if;
    logic dev_scl_o;
    logic dev_scl_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic serial_clock_line;
    logic serial_data_line;

    // Wired-AND with pull-ups: a line is low while any end pulls it low
    assign serial_clock_line = ~((dev_scl_oe & ~dev_scl_o)
                               | (host_scl_oe & ~host_scl_o));
    assign serial_data_line  = ~((dev_sda_oe & ~dev_sda_o)
                               | (host_sda_oe & ~host_sda_o));

    modport dev (
        input  serial_clock_line,
        input  serial_data_line,
        output dev_scl_o,
        output dev_scl_oe,
        output dev_sda_o,
        output dev_sda_oe
    );

    modport host (
        input  serial_clock_line,
        input  serial_data_line,
        output host_scl_o,
        output host_scl_oe,
        output host_sda_o,
        output host_sda_oe
    );
endinterface : sis_bus_if

`default_nettype wire

// ---- sis_device.sv ----
// Sensor end: two-wire register slave with its register storage
//
// What this block does
// RQ1 - Slave only; serial clock at most 1/24.
// RQ2 - One register byte per START-STOP transaction.
// RQ3 - Detect START: data falls, clock high.
// RQ4 - Detect STOP: data rises, clock high.
// RQ5 - Address 0110011 then R/W, MSB first.
// RQ6 - R/W one transmits, zero receives.
// RQ7 - Acknowledge only matching address on ninth pulse.
// RQ8 - Eight bits MSB first; change only clock low.
// RQ9 - Receiver samples data at clock falling edge.
// RQ10 - Receiver acknowledges every byte on ninth pulse; the device leaves a second data byte unacknowledged.
// RQ11 - No acknowledge leaves data line high.
// RQ12 - Master not acknowledging ends data; release line.
// RQ13 - First call byte always carries write.
// RQ14 - Repeated START accepted to change direction.
// RQ15 - STOP right after acknowledge releases bus.
// RQ16 - Slave may stretch clock; master waits.
// RQ17 - Master alone sets clock high time.
// RQ18 - Write: call, register, data, each acknowledged.
// RQ19 - Lines are only pulled low or released.
// RQ20 - Registers can be read back by master.
// RQ21 - Read: call, register, restart, read call, NAK.
// RQ22 - Mismatch: stay released until START or STOP.
// RQ23 - Synchronise lines, detect events from samples.
`timescale 1ns/100ps
`default_nettype none

module sis_device
    import sis_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    sis_bus_if.dev          bus,
    output logic            reg_wr_strobe,
    output logic [7:0]      reg_wr_addr,
    output logic [7:0]      reg_wr_data,
    output logic            selected
);

    // -------------------------------------------------------------
    // Types and state
    // -------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_RX     = 6'b000010,
        ST_ACK    = 6'b000100,
        ST_TX     = 6'b001000,
        ST_MACK   = 6'b010000,
        ST_IGNORE = 6'b100000
    } sis_dev_state_t;

    sis_dev_state_t state;
    logic [2:0]     scl_sync;
    logic [2:0]     sda_sync;
    logic           scl_f;
    logic           sda_f;
    logic           scl_p;
    logic           sda_p;
    logic [3:0]     bit_cnt;
    logic [7:0]     shreg;
    logic [1:0]     phase;
    logic           read_mode;
    logic [7:0]     reg_ptr;
    logic           sda_pull;
    logic           line_low;
    logic           seen_high;
    logic [7:0]     regs [SIS_REG_COUNT];

    // -------------------------------------------------------------
    // Line synchronisers and filtered levels
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_f    <= 1'b1;
            sda_f    <= 1'b1;
            scl_p    <= 1'b1;
            sda_p    <= 1'b1;
        end else if (clk_en) begin
            scl_sync <= {scl_sync[1:0], bus.serial_clock_line};   // [RQ23]
            sda_sync <= {sda_sync[1:0], bus.serial_data_line};    // [RQ23]
            if (scl_sync[1] == scl_sync[2]) begin
                scl_f <= scl_sync[2];
            end
            if (sda_sync[1] == sda_sync[2]) begin
                sda_f <= sda_sync[2];
            end
            scl_p <= scl_f;
            sda_p <= sda_f;
        end
    end

    // -------------------------------------------------------------
    // Bus events and decode
    // -------------------------------------------------------------
    wire        start_det  = scl_f & scl_p & sda_p & ~sda_f;    // [RQ3]
    wire        stop_det   = scl_f & scl_p & ~sda_p & sda_f;    // [RQ4]
    wire        scl_fall   = scl_p & ~scl_f;                     // [RQ9]
    wire        scl_rise   = scl_f & ~scl_p;
    wire        last_bit   = (bit_cnt == SIS_LAST_DATA_BIT);
    wire [7:0]  rx_byte    = {shreg[6:0], sda_f};                // [RQ8]
    wire        addr_match = (rx_byte[7:1] == SIS_SLAVE_ADDR);   // [RQ5]
    // The clock fall that follows a START carries no bit
    wire        bit_event  = scl_fall & seen_high & ~start_det & ~stop_det;
    wire        rx_done    = bit_event & (state == ST_RX) & last_bit;
    wire        mem_we     = rx_done & (phase == SIS_PH_DATA);   // [RQ18]
    wire [7:0]  rd_byte    = regs[reg_ptr];                      // [RQ20]

    // -------------------------------------------------------------
    // Register storage
    // -------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < SIS_REG_COUNT; gi = gi + 1) begin : g_reg
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    regs[gi] <= 8'h00;
                end else if (clk_en && mem_we && reg_ptr == 8'(gi)) begin
                    regs[gi] <= rx_byte;                         // [RQ18]
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------
    // Protocol state machine
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state         <= ST_IDLE;
            bit_cnt       <= 4'h0;
            shreg         <= 8'h00;
            phase         <= SIS_PH_CALL;
            read_mode     <= 1'b0;
            reg_ptr       <= 8'h00;
            sda_pull      <= 1'b0;
            line_low      <= 1'b0;
            seen_high     <= 1'b0;
            reg_wr_strobe <= 1'b0;
            reg_wr_addr   <= 8'h00;
            reg_wr_data   <= 8'h00;
            selected      <= 1'b0;
        end else if (clk_en) begin
            reg_wr_strobe <= mem_we;
            if (mem_we) begin
                reg_wr_addr <= reg_ptr;
                reg_wr_data <= rx_byte;
            end
            if (scl_rise) begin
                seen_high <= 1'b1;
            end else if (scl_fall) begin
                seen_high <= 1'b0;
            end
            if (stop_det) begin
                state    <= ST_IDLE;                             // [RQ4] [RQ15]
                sda_pull <= 1'b0;
                selected <= 1'b0;
            end else if (start_det) begin
                // Repeated START keeps the register pointer
                state    <= ST_RX;                               // [RQ14]
                seen_high <= 1'b0;                               // [RQ3]
                bit_cnt  <= 4'h0;
                phase    <= SIS_PH_CALL;
                sda_pull <= 1'b0;
                selected <= 1'b0;
            end else if (bit_event) begin
                case (state)
                    ST_RX: begin
                        shreg   <= rx_byte;
                        bit_cnt <= bit_cnt + 4'h1;
                        if (last_bit) begin
                            phase <= phase + 2'h1;
                            case (phase)
                                SIS_PH_CALL: begin
                                    if (addr_match) begin
                                        read_mode <= rx_byte[0]; // [RQ6]
                                        sda_pull  <= 1'b1;       // [RQ7]
                                        state     <= ST_ACK;
                                        selected  <= 1'b1;
                                    end else begin
                                        state     <= ST_IGNORE;  // [RQ22]
                                    end
                                end
                                SIS_PH_REG: begin
                                    reg_ptr  <= rx_byte;         // [RQ13]
                                    sda_pull <= 1'b1;            // [RQ10]
                                    state    <= ST_ACK;
                                end
                                SIS_PH_DATA: begin
                                    sda_pull <= 1'b1;            // [RQ10]
                                    state    <= ST_ACK;
                                end
                                default: begin
                                    // Second data byte: not acknowledged
                                    state <= ST_IGNORE;          // [RQ2] [RQ11]
                                end
                            endcase
                        end
                    end
                    ST_ACK: begin
                        bit_cnt <= 4'h0;
                        if (read_mode) begin
                            shreg    <= rd_byte;                 // [RQ20]
                            sda_pull <= ~rd_byte[7];             // [RQ6] [RQ19]
                            state    <= ST_TX;
                            phase    <= SIS_PH_DONE;
                        end else begin
                            sda_pull <= 1'b0;
                            state    <= ST_RX;
                        end
                    end
                    ST_TX: begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (last_bit) begin
                            sda_pull <= 1'b0;
                            state    <= ST_MACK;
                        end else begin
                            sda_pull <= ~shreg[6];               // [RQ8]
                            shreg    <= {shreg[6:0], 1'b0};
                        end
                    end
                    ST_MACK: begin
                        // One byte per transaction, acknowledged or not
                        state <= ST_IGNORE;                      // [RQ12] [RQ2]
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end
        end
    end

    // -------------------------------------------------------------
    // Open-drain pins: only low or released, clock never held
    // -------------------------------------------------------------
    assign bus.dev_sda_o  = line_low;                            // [RQ19]
    assign bus.dev_sda_oe = sda_pull;
    assign bus.dev_scl_o  = line_low;
    assign bus.dev_scl_oe = line_low;                            // [RQ1]

endmodule : sis_device

`default_nettype wire

// ---- sis_host.sv ----
// Bus master end: single-register write and read over the two-wire link
`timescale 1ns/100ps
`default_nettype none

module sis_host
    import sis_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    sis_bus_if.host         bus,
    input  wire logic       cmd_valid,
    input  wire logic       cmd_read,
    input  wire logic [7:0] cmd_reg,
    input  wire logic [7:0] cmd_data,
    output logic            cmd_ready,
    output logic            done,
    output logic            done_nack,
    output logic [7:0]      rd_data
);

    // -------------------------------------------------------------
    // Types and state
    // -------------------------------------------------------------
    typedef enum logic [3:0] {
        HS_IDLE  = 4'b0001,
        HS_START = 4'b0010,
        HS_BYTE  = 4'b0100,
        HS_STOP  = 4'b1000
    } sis_host_state_t;

    sis_host_state_t state;
    logic [2:0]      scl_sync;
    logic [2:0]      sda_sync;
    logic            scl_hi;
    logic            sda_hi;
    logic [3:0]      qcnt;
    logic [1:0]      quarter;
    logic [2:0]      step;
    logic [3:0]      bit_cnt;
    logic [7:0]      shreg;
    logic            rd_op;
    logic [7:0]      reg_idx;
    logic [7:0]      wr_val;
    logic            scl_pull;
    logic            sda_pull;
    logic            nack;
    logic            line_low;

    // -------------------------------------------------------------
    // Line synchronisers
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_hi   <= 1'b1;
            sda_hi   <= 1'b1;
        end else if (clk_en) begin
            scl_sync <= {scl_sync[1:0], bus.serial_clock_line};
            sda_sync <= {sda_sync[1:0], bus.serial_data_line};
            if (scl_sync[1] == scl_sync[2]) begin
                scl_hi <= scl_sync[2];
            end
            if (sda_sync[1] == sda_sync[2]) begin
                sda_hi <= sda_sync[2];
            end
        end
    end

    // -------------------------------------------------------------
    // Quarter-bit timing and sequence decode
    // -------------------------------------------------------------
    // High phase only counts once the line is really high
    wire        hold_wait = (quarter == 2'h2) & ~scl_hi;          // [RQ16]
    wire        q_end     = (qcnt == SIS_QUARTER_LAST) & ~hold_wait;
    wire        ack_slot  = (bit_cnt == SIS_ACK_BIT);
    wire        rx_byte   = rd_op & (step == SIS_STEP_LAST_RD);
    wire        last_step = rd_op ? (step == SIS_STEP_LAST_RD)
                                  : (step == SIS_STEP_LAST_WR);
    wire        next_rs   = rd_op & (step == SIS_STEP_REG);
    // START loads the byte of this step, a byte end loads the next one
    wire [2:0]  load_step = (state == HS_START) ? step : step + 3'h1;
    wire        load_rdc  = rd_op & (load_step == SIS_STEP_LAST_RD - 3'h1);
    wire [7:0]  step_byte = (load_step == 3'h0) ? SIS_CALL_WRITE  // [RQ13]
                          : (load_step == SIS_STEP_REG) ? reg_idx
                          : load_rdc ? SIS_CALL_READ              // [RQ21]
                          : wr_val;
    // Host drives data bits of bytes it sends; releases elsewhere
    wire        out_bit   = ack_slot ? 1'b1                        // [RQ12]
                          : (rx_byte ? 1'b1 : shreg[7]);
    wire        done_byte = q_end & (quarter == 2'h3) & ack_slot;

    // -------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state     <= HS_IDLE;
            qcnt      <= 4'h0;
            quarter   <= 2'h0;
            step      <= 3'h0;
            bit_cnt   <= 4'h0;
            shreg     <= 8'h00;
            rd_op     <= 1'b0;
            reg_idx   <= 8'h00;
            wr_val    <= 8'h00;
            scl_pull  <= 1'b0;
            sda_pull  <= 1'b0;
            nack      <= 1'b0;
            line_low  <= 1'b0;
            cmd_ready <= 1'b1;
            done      <= 1'b0;
            done_nack <= 1'b0;
            rd_data   <= 8'h00;
        end else if (clk_en) begin
            done <= 1'b0;
            if (state != HS_IDLE) begin
                qcnt <= q_end ? 4'h0 : (hold_wait ? qcnt : qcnt + 4'h1);
                if (q_end) begin
                    quarter <= quarter + 2'h1;
                end
            end
            case (state)
                HS_IDLE: begin
                    if (cmd_valid) begin
                        rd_op     <= cmd_read;
                        reg_idx   <= cmd_reg;
                        wr_val    <= cmd_data;
                        step      <= 3'h0;
                        nack      <= 1'b0;
                        cmd_ready <= 1'b0;
                        qcnt      <= 4'h0;
                        quarter   <= 2'h0;
                        state     <= HS_START;
                    end
                end
                HS_START: begin
                    if (q_end) begin
                        case (quarter)
                            2'h0: sda_pull <= 1'b0;
                            2'h1: scl_pull <= 1'b0;
                            2'h2: sda_pull <= 1'b1;              // [RQ3]
                            default: begin
                                scl_pull <= 1'b1;
                                shreg    <= step_byte;
                                bit_cnt  <= 4'h0;
                                state    <= HS_BYTE;
                            end
                        endcase
                    end
                end
                HS_BYTE: begin
                    if (q_end) begin
                        case (quarter)
                            2'h0: sda_pull <= ~out_bit;          // [RQ8]
                            2'h1: scl_pull <= 1'b0;              // [RQ17]
                            2'h2: scl_pull <= 1'b0;
                            default: begin
                                // Sample just before pulling clock low
                                scl_pull <= 1'b1;                // [RQ9]
                                bit_cnt  <= bit_cnt + 4'h1;
                                if (!ack_slot) begin
                                    shreg <= {shreg[6:0], sda_hi};
                                end
                            end
                        endcase
                        if (done_byte) begin
                            step <= step + 3'h1;
                            if (rx_byte) begin
                                rd_data <= shreg;                // [RQ21]
                                state   <= HS_STOP;
                            end else if (sda_hi) begin
                                nack  <= 1'b1;                   // [RQ11]
                                state <= HS_STOP;
                            end else if (last_step) begin
                                state <= HS_STOP;                // [RQ18]
                            end else if (next_rs) begin
                                state <= HS_START;               // [RQ14]
                            end else begin
                                shreg   <= step_byte;
                                bit_cnt <= 4'h0;
                            end
                        end
                    end
                end
                HS_STOP: begin
                    if (q_end) begin
                        case (quarter)
                            2'h0: sda_pull <= 1'b1;
                            2'h1: scl_pull <= 1'b0;
                            2'h2: sda_pull <= 1'b1;
                            default: begin
                                sda_pull  <= 1'b0;               // [RQ4]
                                done      <= 1'b1;
                                done_nack <= nack;
                                cmd_ready <= 1'b1;
                                state     <= HS_IDLE;
                            end
                        endcase
                    end
                end
                default: state <= HS_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------
    // Open-drain pins
    // -------------------------------------------------------------
    assign bus.host_scl_o  = line_low;
    assign bus.host_scl_oe = scl_pull;                           // [RQ1]
    assign bus.host_sda_o  = line_low;
    assign bus.host_sda_oe = sda_pull;

endmodule : sis_host

`default_nettype wire

// ---- sis_link_properties.sv ----
// Link assertions
`timescale 1ns/100ps
`default_nettype none
module sis_link_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic dev_scl_o,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic serial_clock_line,
    input wire logic serial_data_line
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_pin; !dev_scl_o && !dev_sda_o; endproperty
    a_pin: assert property (p_pin) else $error("pin high");
    property p_lag; $fell(serial_clock_line) |=> $stable(dev_sda_oe) [*2];
    endproperty
    a_lag: assert property (p_lag) else $error("fast");
    property p_hold; serial_clock_line && $past(serial_clock_line)
        |-> $stable(dev_sda_oe); endproperty
    a_hold: assert property (p_hold) else $error("moved");
    property p_ack; $rose(dev_sda_oe) |-> dev_sda_oe
        throughout (##[1:12] $rose(serial_clock_line)); endproperty
    a_ack: assert property (p_ack) else $error("short pull");
    property p_rel; $rose(dev_sda_oe) |-> ##[1:320] !dev_sda_oe; endproperty
    a_rel: assert property (p_rel) else $error("held");
    property p_stop; serial_clock_line && $rose(serial_data_line)
        |=> !dev_sda_oe [*8]; endproperty
    a_stop: assert property (p_stop) else $error("stop pull");
    property p_low; $fell(serial_clock_line) |-> !serial_clock_line [*8];
    endproperty
    a_low: assert property (p_low) else $error("low short");
    property p_high; $rose(serial_clock_line) |-> serial_clock_line [*4];
    endproperty
    a_high: assert property (p_high) else $error("high short");
endmodule : sis_link_chk
`default_nettype wire

// ---- test_sensor_i2c_register_slave.sv ----
// Slave and master bench
`timescale 1ns/100ps
`default_nettype none
module test_sensor_i2c_register_slave;
    import sis_pkg::*;
    logic sys_clk = 1'h0, rst = 1'h1, ps = 1'h1, go = 1'h0, rd = 1'h0;
    logic en = 1'h1;
    logic [7:0] rg = 8'h00, wd = 8'h00, n_wr = 8'h00;
    logic [27:0] sh = 28'h0;
    logic rdy, done, nak, stb, sel;
    logic [7:0] rdat, wa, wdat;
    int mismatches = 0, total_checks = 0, cycles = 0;
    sis_bus_if ln ();
    sis_device sis_device_inst (.sys_clk, .rst, .clk_en(en), .bus(ln),
        .reg_wr_strobe(stb), .reg_wr_addr(wa), .reg_wr_data(wdat),
        .selected(sel));
    sis_host sis_host_inst (.sys_clk, .rst, .clk_en(en), .bus(ln),
        .cmd_valid(go), .cmd_read(rd), .cmd_reg(rg), .cmd_data(wd),
        .cmd_ready(rdy), .done, .done_nack(nak), .rd_data(rdat));
    sis_link_chk sis_link_chk_inst (.sys_clk, .rst,
        .dev_scl_o(ln.dev_scl_o), .dev_sda_o(ln.dev_sda_o),
        .dev_sda_oe(ln.dev_sda_oe),
        .serial_clock_line(ln.serial_clock_line),
        .serial_data_line(ln.serial_data_line));
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        ps <= ln.serial_clock_line;
        if (ln.serial_clock_line && !ps)
            sh <= {sh[26:0], ln.serial_data_line};
        if (stb)
            n_wr <= n_wr + 8'h01;
        cycles <= cycles + 1;
        // Both ends freeze for four cycles inside the first write
        en <= (cycles < 300) || (cycles > 303);
        if (cycles == 12000)
            close_out();
    end
    task automatic chk(input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %0t %h %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cmd(input logic r, input logic [7:0] a, d);
        {go, rd, rg, wd} <= {1'h1, r, a, d};
        @(posedge sys_clk);
        go <= 1'h0;
        @(posedge sys_clk iff done);
        chk({nak, rdy}, 2'h1);
    endtask : cmd
    task automatic close_out();
        if (cycles >= 12000)
            mismatches++;
        $display("checks %0d errors %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'h0;
        @(posedge sys_clk);
        cmd(1'h0, 8'h00, 8'h5A);
        chk(sh, {SIS_CALL_WRITE, 1'h0, 8'h00, 1'h0, 8'h5A, 2'h0});
        cmd(1'h0, 8'hFF, 8'hA5);
        chk({wa, wdat, n_wr}, 24'hFFA502);
        $display("write test over");
        cmd(1'h1, 8'hFF, 8'h00);
        chk(rdat, 8'hA5);
        cmd(1'h1, 8'h00, 8'h00);
        chk(rdat, 8'h5A);
        cmd(1'h1, 8'h7F, 8'h00);
        chk(sh[18:0], {SIS_CALL_READ, 1'h0, 8'h00, 2'h2});
        repeat (12) @(posedge sys_clk);
        chk(sel, 1'h0);
        $display("read test over");
        close_out();
    end
endmodule : test_sensor_i2c_register_slave
`default_nettype wire
